// [logic/trwe_pkg.sv]
// Purpose: Shared constants for the trigger readout word encoder
// Assumes: 32-bit readout words, APB register access
// Notes: Word layouts, tags, register offsets and reset values
`default_nettype none
package trwe_pkg;
  // ---------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int DEF_BIT = 31;
  localparam int TAG_HI = 30;
  localparam int TAG_LO = 27;
  localparam int KIND_HI = 26;
  localparam int KIND_LO = 23;
  localparam int RES_HI = 22;
  localparam int RES_LO = 16;
  localparam int TIME_W = 9;
  localparam logic [3:0] TAG_BLK_HDR = 4'h0;
  localparam logic [3:0] TAG_BLK_TRL = 4'h1;
  localparam logic [3:0] TAG_TRIGGER = 4'h5;
  localparam logic [3:0] TAG_NODATA = 4'hE;
  localparam logic [3:0] TAG_FILLER = 4'hF;
  // Trigger kinds
  localparam logic [3:0] KIND_PAIR0 = 4'h6;
  localparam logic [3:0] KIND_PAIR1 = 4'h7;
  localparam logic [3:0] KIND_SGL_LO = 4'h2;
  localparam logic [3:0] KIND_SGL_HI = 4'h5;
  // Block header/trailer fields
  localparam int SLOT_LO = 22;
  localparam int BLKNUM_LO = 8;
  localparam int BLKNUM_W = 10;
  localparam int CNT_W = 22;
  // ---------------------------------------------------------------
  // Registers (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_BLKSZ = 8'h0C;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [7:0] BLKSZ_RST = 8'h01;
  localparam int CTRL_EN = 0;
  localparam int CTRL_PAD4 = 1;
  localparam int CTRL_SLOT_LO = 8;
  localparam int FIFO_DEPTH = 16;
  // Readout rate in Mbit/s the path is sized for
  localparam int RATE_MBPS = 200;
endpackage : trwe_pkg
`default_nettype wire

// [logic/trwe_fifo.sv]
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, asynchronous active-low reset
// Notes: Full and empty derived from an occupancy count
`timescale 1ns/1ns
`default_nettype none
module trwe_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Handshakes
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_r];

  // Storage
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : trwe_fifo
`default_nettype wire

// [logic/trwe_encoder.sv]
// Purpose: Packs trigger results into tagged readout words over APB
// Assumes: APB3 slave at 50 MHz, found triggers are held valid until trig_ready takes them
// Notes: Reading the data register pops one word or gives a no-data word
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module trwe_encoder #(
  parameter int DEPTH = trwe_pkg::FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trig_valid,
  input wire logic [3:0] trig_kind,
  input wire logic [6:0] trig_cuts,
  input wire logic [8:0] trig_time,
  output logic trig_ready
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_BODY = 3'b010,
    ST_TRL = 3'b011,
    ST_PAD = 3'b100
  } trwe_state_t;

  // ---------------------------------------------------------------
  // Word builders
  // ---------------------------------------------------------------
  function automatic logic [31:0] trwe_tagged(input logic [3:0] tag,
                                              input logic [26:0] body);
    trwe_tagged = {1'b1, tag, body};
  endfunction : trwe_tagged

  function automatic logic [6:0] trwe_result(input logic [3:0] kind,
                                             input logic [6:0] cuts);
    logic [6:0] res;
    res = 7'h00;
    if (kind >= trwe_pkg::KIND_SGL_LO && kind <= trwe_pkg::KIND_SGL_HI) begin
      res = {4'h0, cuts[2:0]};
    end else if (kind == trwe_pkg::KIND_PAIR0 ||
                 kind == trwe_pkg::KIND_PAIR1) begin
      res = {3'h0, cuts[3:0]};
    end
    trwe_result = res;
  endfunction : trwe_result

  // True when the bus address selects the given register
  function automatic logic trwe_hit(input logic [7:0] addr,
                                    input logic [7:0] offset);
    trwe_hit = (addr == offset);
  endfunction : trwe_hit

  // Control image: enable and pad mode low, slot id at its own field
  function automatic logic [31:0] trwe_ctrl_img(input logic en,
                                                input logic pad4,
                                                input logic [4:0] slot);
    logic [31:0] img;
    img = 32'h00000000;
    img[trwe_pkg::CTRL_EN] = en;
    img[trwe_pkg::CTRL_PAD4] = pad4;
    img[trwe_pkg::CTRL_SLOT_LO +: 5] = slot;
    trwe_ctrl_img = img;
  endfunction : trwe_ctrl_img

  // Status image: blocks done, framing state and buffer data flag
  function automatic logic [31:0] trwe_status_img(input logic [15:0] done,
                                                  input logic [2:0] st,
                                                  input logic has_data);
    trwe_status_img = {done, 5'h00, st, 7'h00, has_data};
  endfunction : trwe_status_img

  // Block header: slot id, block number and events per block
  function automatic logic [31:0] trwe_hdr_word(
    input logic [4:0] slot,
    input logic [trwe_pkg::BLKNUM_W-1:0] num,
    input logic [7:0] size);
    trwe_hdr_word = trwe_tagged(trwe_pkg::TAG_BLK_HDR,
                                {slot, 4'h0, num, size});
  endfunction : trwe_hdr_word

  // Block trailer: slot id and words from header to trailer
  function automatic logic [31:0] trwe_trl_word(
    input logic [4:0] slot,
    input logic [trwe_pkg::CNT_W-1:0] cnt);
    trwe_trl_word = trwe_tagged(trwe_pkg::TAG_BLK_TRL,
                                {slot, cnt});
  endfunction : trwe_trl_word

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic enable_r;
  logic pad4_r;
  logic [4:0] slot_r;
  logic [7:0] blksz_r;
  trwe_state_t state_r;
  logic [7:0] evt_cnt_r;
  logic [trwe_pkg::CNT_W-1:0] words_r;
  logic [trwe_pkg::BLKNUM_W-1:0] blknum_r;
  logic [31:0] blocks_done_r;
  logic [31:0] enc_word;
  logic enc_valid;
  logic enc_ready;
  logic [31:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic wr_en;
  logic rd_en;
  logic [trwe_pkg::CNT_W-1:0] words_total;
  logic pad_done;
  logic rd_setup;
  logic rd_hit_r;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  // Single-cycle access phase, never an error
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Total count including the trailer about to go out
  assign words_total = words_r + 1'b1;
  // Padding done once the count reaches the selected multiple
  assign pad_done = pad4_r ? (words_r[1:0] == 2'b00)
                           : (words_r[0] == 1'b0);

  // ---------------------------------------------------------------
  // Configuration writes
  // ---------------------------------------------------------------
  // Control register: enable, pad mode and slot id
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= trwe_pkg::CTRL_RST[trwe_pkg::CTRL_EN];
      pad4_r <= trwe_pkg::CTRL_RST[trwe_pkg::CTRL_PAD4];
      slot_r <= trwe_pkg::CTRL_RST[trwe_pkg::CTRL_SLOT_LO +: 5];
    end else if (wr_en && trwe_hit(paddr, trwe_pkg::REG_CTRL)) begin
      enable_r <= pwdata[trwe_pkg::CTRL_EN];
      pad4_r <= pwdata[trwe_pkg::CTRL_PAD4];
      slot_r <= pwdata[trwe_pkg::CTRL_SLOT_LO +: 5];
    end
  end

  // Events per block, zero is taken as one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blksz_r <= trwe_pkg::BLKSZ_RST;
    end else if (wr_en && trwe_hit(paddr, trwe_pkg::REG_BLKSZ)) begin
      blksz_r <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Block framing state machine
  // ---------------------------------------------------------------
  // Header, trigger words, trailer, then fillers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      evt_cnt_r <= 8'h00;
      words_r <= '0;
      blknum_r <= '0;
      blocks_done_r <= 32'h00000000;
    end else begin
      case (state_r)
        // Wait for a trigger to open a block
        ST_IDLE: begin
          if (enable_r && trig_valid) begin
            state_r <= ST_HDR;
            words_r <= '0;
            evt_cnt_r <= 8'h00;
          end
        end
        // Header goes out once the buffer has room
        ST_HDR: begin
          if (enc_ready) begin
            state_r <= ST_BODY;
            words_r <= words_r + 1'b1;
          end
        end
        // One word per accepted trigger until the block is full
        ST_BODY: begin
          if (trig_valid && enc_ready) begin
            words_r <= words_r + 1'b1;
            evt_cnt_r <= evt_cnt_r + 1'b1;
            if (evt_cnt_r + 8'h01 == blksz_r) begin
              state_r <= ST_TRL;
            end
          end
        end
        // Trailer closes the block and counts itself
        ST_TRL: begin
          if (enc_ready) begin
            words_r <= words_total;
            state_r <= ST_PAD;
          end
        end
        // Fillers until the word count is aligned
        ST_PAD: begin
          if (pad_done) begin
            state_r <= ST_IDLE;
            blknum_r <= blknum_r + 1'b1;
            blocks_done_r <= blocks_done_r + 32'h00000001;
          end else if (enc_ready) begin
            words_r <= words_r + 1'b1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Word encoding into the buffer
  // ---------------------------------------------------------------
  // Selects the word for the current framing step
  always_comb begin
    enc_word = 32'h00000000;
    enc_valid = 1'b0;
    trig_ready = 1'b0;
    case (state_r)
      // Header opens the block
      ST_HDR: begin
        enc_valid = 1'b1;
        enc_word = trwe_hdr_word(slot_r, blknum_r, blksz_r);
      end
      // Trigger word straight from the offered result
      ST_BODY: begin
        enc_valid = trig_valid;
        trig_ready = enc_ready;
        enc_word = trwe_tagged(trwe_pkg::TAG_TRIGGER,
                               {trig_kind,
                                trwe_result(trig_kind, trig_cuts),
                                7'h00, trig_time});
      end
      // Trailer carries the block's word count
      ST_TRL: begin
        enc_valid = 1'b1;
        enc_word = trwe_trl_word(slot_r, words_total);
      end
      // Filler words while the count is unaligned
      ST_PAD: begin
        enc_valid = !pad_done;
        enc_word = trwe_tagged(trwe_pkg::TAG_FILLER, 27'h0);
      end
      // Nothing to write while idle
      default: begin
        enc_valid = 1'b0;
      end
    endcase
  end

  // Event buffer; a full buffer stalls the trigger source
  trwe_fifo #(
    .WIDTH(trwe_pkg::WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_data(enc_word),
    .in_valid(enc_valid),
    .in_ready(enc_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // ---------------------------------------------------------------
  // Readout
  // ---------------------------------------------------------------
  // One word per data-register read, at most every other cycle (setup then access)
  assign fifo_pop = rd_en && rd_hit_r &&
                    trwe_hit(paddr, trwe_pkg::REG_DATA);

  // ---------------------------------------------------------------
  // Read bookkeeping
  // ---------------------------------------------------------------
  // Pops only the word that the setup returned; a word landing between
  // setup and access stays for the next read instead of being lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_hit_r <= 1'b0;
    end else if (rd_setup) begin
      rd_hit_r <= trwe_hit(paddr, trwe_pkg::REG_DATA) && fifo_valid;
    end
  end

  // Read data is registered in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr)
        trwe_pkg::REG_CTRL: begin
          prdata <= trwe_ctrl_img(enable_r, pad4_r, slot_r);
        end
        trwe_pkg::REG_STATUS: begin
          prdata <= trwe_status_img(blocks_done_r[15:0], state_r,
                                    fifo_valid);
        end
        trwe_pkg::REG_DATA: begin
          if (fifo_valid) begin
            prdata <= fifo_data;
          end else begin
            prdata <= trwe_tagged(trwe_pkg::TAG_NODATA,
                                  27'h0);
          end
        end
        trwe_pkg::REG_BLKSZ: begin
          prdata <= {24'h0, blksz_r};
        end
        default: begin
          prdata <= 32'h00000000;
        end
      endcase
    end
  end
endmodule : trwe_encoder
`default_nettype wire

// [test/trwe_encoder_sva.sv]
// Purpose: Port checker for the readout word encoder
// Assumes: Zero-wait APB, prdata loaded at read setup
// Notes: Bound to every encoder instance
`timescale 1ns/1ns
`default_nettype none
module trwe_encoder_sva #(
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ----------------------------------------
  // Clean access responses, and word checks on data register reads
  // ----------------------------------------
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Setup of a data read, then the word it returns
  sequence s_rd;
    psel && !penable && !pwrite && paddr == trwe_pkg::REG_DATA;
  endsequence
  sequence s_tag(logic [3:0] t);
    s_rd ##1 prdata[30:27] == t;
  endsequence
  AST_ZERO_WAIT: assert property (psel && penable |-> pready && !pslverr)
    else $error("access not answered cleanly");
  AST_DEF_BIT: assert property (s_rd |=> prdata[31])
    else $error("data word without defining bit");
  AST_TAG_KNOWN: assert property (s_rd |=>
    prdata[30:27] inside {4'h0, 4'h1, 4'h5, 4'hE, 4'hF})
    else $error("unknown word tag");
  AST_KIND_RANGE: assert property (s_tag(4'h5) |-> !prdata[26])
    else $error("trigger kind out of range");
  AST_COSMIC: assert property (s_tag(4'h5) ##0 prdata[26:24] == 3'h0
    |-> prdata[22:16] == 7'h00)
    else $error("cosmic result not zero");
  AST_SINGLES: assert property (s_tag(4'h5)
    ##0 prdata[26:23] inside {[4'h2:4'h5]} |-> prdata[22:19] == 4'h0)
    else $error("singles result has stray bits");
  AST_PAIR: assert property (s_tag(4'h5) ##0 prdata[26:24] == 3'h3
    |-> prdata[22:20] == 3'h0)
    else $error("pair result has stray bits");
  AST_TIME_GAP: assert property (s_tag(4'h5) |-> prdata[15:9] == 7'h00)
    else $error("trigger time gap not zero");
  AST_NODATA: assert property (s_tag(4'hE) |-> prdata[26:0] == 27'h0)
    else $error("no-data word body not zero");
  AST_FILLER: assert property (s_tag(4'hF) |-> prdata[26:0] == 27'h0)
    else $error("filler word body not zero");
endmodule : trwe_encoder_sva
bind trwe_encoder trwe_encoder_sva #(.DEPTH(DEPTH)) trwe_encoder_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));
`default_nettype wire

// [test/trwe_host.sv]
// Purpose: Host model reading the encoder over APB
// Assumes: Single aligned 32-bit transfers only
// Notes: Address and data are scrambled while unselected
`timescale 1ns/1ns
`default_nettype none
module trwe_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  // ----------------------------------------
  // Bus transfer
  // ----------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One setup cycle, then access until pready
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : trwe_host
`default_nettype wire

// [test/tb_top.sv]
// Purpose: Self-checking bench for the readout word encoder
// Assumes: Host model speaks APB, triggers driven here
// Notes: First block overfills the buffer to force a stall
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, trig_ready;
  logic trig_valid = 1'b0;
  logic [3:0] trig_kind = 4'h0;
  logic [6:0] trig_cuts = 7'h00;
  logic [8:0] trig_time = 9'h000;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int err_count = 0;
  int n_compared = 0;
  // ----------------------------------------
  // Clock, parts and helpers
  // ----------------------------------------
  always #10 pclk = ~pclk;
  trwe_encoder trwe_encoder_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_valid(trig_valid), .trig_kind(trig_kind), .trig_cuts(trig_cuts),
    .trig_time(trig_time), .trig_ready(trig_ready));
  trwe_host trwe_host_i (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Read a register and compare the masked word
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
    input logic [31:0] m = 32'hFFFFFFFF);
    trwe_host_i.xfer(1'b0, a, 32'h0, q);
    chk(q & m, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    trwe_host_i.xfer(1'b1, a, d, q);
  endtask : wr
  // Offer one trigger and hold it until it is taken
  task automatic send(input logic [3:0] k, input logic [6:0] c,
    input logic [8:0] t);
    trig_valid <= 1'b1;
    trig_kind <= k;
    trig_cuts <= c;
    trig_time <= t;
    do @(negedge pclk); while (trig_ready !== 1'b1);
    @(posedge pclk);
  endtask : send
  // Expected trigger word, cut bits masked by kind
  function automatic logic [31:0] tword(input logic [3:0] k,
    input logic [6:0] c, input logic [8:0] t);
    logic [6:0] r;
    r = (k < 4'h2) ? 7'h00 : (k < 4'h6) ? {4'h0, c[2:0]} : {3'h0, c[3:0]};
    return {1'b1, 4'h5, k, r, 7'h00, t};
  endfunction : tword
  task automatic final_report;
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(trwe_pkg::REG_CTRL, trwe_pkg::CTRL_RST);
    rd(trwe_pkg::REG_BLKSZ, {24'h0, trwe_pkg::BLKSZ_RST});
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0);
    rd(trwe_pkg::REG_DATA, 32'hF0000000);
    wr(trwe_pkg::REG_BLKSZ, 32'h10);
    wr(trwe_pkg::REG_CTRL, 32'h0A03);
    fork
      begin
        for (int i = 0; i < 16; i++) begin
          send(i[3:0] & 4'h7, {3'h7, i[3:0]}, 9'h1F0 + i[8:0]);
        end
        trig_valid <= 1'b0;
      end
    join_none
    repeat (40) @(negedge pclk);
    chk({31'h0, trig_ready}, 32'h0);
    rd(trwe_pkg::REG_DATA, 32'h82800010);
    for (int i = 0; i < 16; i++) begin
      rd(trwe_pkg::REG_DATA, tword(i[3:0] & 4'h7, {3'h7, i[3:0]},
        9'h1F0 + i[8:0]));
    end
    rd(trwe_pkg::REG_DATA, 32'h8A800012);
    repeat (2) rd(trwe_pkg::REG_DATA, 32'hF8000000);
    rd(trwe_pkg::REG_DATA, 32'hF0000000);
    wait fork;
    wr(trwe_pkg::REG_BLKSZ, 32'h1);
    wr(trwe_pkg::REG_CTRL, 32'h0A01);
    rd(trwe_pkg::REG_CTRL, 32'h00000A01);
    send(4'h6, 7'h05, 9'h000);
    trig_valid <= 1'b0;
    rd(trwe_pkg::REG_DATA, 32'h82800101);
    rd(trwe_pkg::REG_DATA, tword(4'h6, 7'h05, 9'h000));
    rd(trwe_pkg::REG_DATA, 32'h8A800003);
    rd(trwe_pkg::REG_DATA, 32'hF8000000);
    rd(trwe_pkg::REG_DATA, 32'hF0000000);
    rd(trwe_pkg::REG_STATUS, 32'h00020000);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
